// ---- hdl/secac_pkg.sv ----
/*
 * Constants shared by the security and settings-access controller: port
 * addresses, subcommand codes, tier codes, link-select codes and timing.
 * Assumes a 100 MHz core clock.
 */
package secac_pkg;

    // ****************************************************************
    // Host-visible byte addresses
    // ****************************************************************
    localparam logic [7:0]  ADDR_SUB_LO    = 8'h3e;
    localparam logic [7:0]  ADDR_SUB_HI    = 8'h3f;
    localparam logic [7:0]  ADDR_BUF_FIRST = 8'h40;
    localparam logic [7:0]  ADDR_BUF_LAST  = 8'h47;
    localparam logic [7:0]  ADDR_CSUM      = 8'h60;
    localparam logic [7:0]  ADDR_LEN       = 8'h61;
    localparam int          BUF_BYTES      = 8;
    localparam int          KEY_WORDS      = 4;

    // ****************************************************************
    // Subcommands
    // ****************************************************************
    localparam logic [15:0] CMD_ENTER_EDIT = 16'h0090;
    localparam logic [15:0] CMD_LEAVE_EDIT = 16'h0092;
    localparam logic [15:0] CMD_ON_BOOT_BIT_A       = 16'h0030;
    localparam logic [15:0] CMD_KEY_STORE  = 16'h0035;
    localparam logic [7:0]  KEY_STORE_LEN  = 8'h0a;

    // ****************************************************************
    // Tier status codes {tier_bit_high, tier_bit_low}
    // ****************************************************************
    localparam logic [1:0]  TIER_CODE_NONE   = 2'h0;
    localparam logic [1:0]  TIER_CODE_LOCKED = 2'h3;
    localparam logic [1:0]  TIER_CODE_OPENED = 2'h2;
    localparam logic [1:0]  TIER_CODE_FULL   = 2'h1;

    // ****************************************************************
    // Link-select codes
    // ****************************************************************
    localparam logic [7:0]  LSEL_DEFAULT    = 8'h00;
    localparam logic [7:0]  LSEL_SINGLE     = 8'h03;
    localparam logic [7:0]  LSEL_STD        = 8'h07;
    localparam logic [7:0]  LSEL_FAST       = 8'h08;
    localparam logic [7:0]  LSEL_FAST_TMO   = 8'h09;
    localparam logic [7:0]  LSEL_STD_CRC    = 8'h11;
    localparam logic [7:0]  LSEL_FAST_CRC   = 8'h12;
    localparam logic [7:0]  LSEL_STD_TMO    = 8'h1e;
    localparam logic [7:0]  LSEL_FAST_ALT   = 8'hff;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint      CLK_HZ          = 100000000;
    localparam longint      KEY_WIN_S       = 4;
    localparam logic [31:0] KEY_WIN_CYC     = 32'(KEY_WIN_S * CLK_HZ);

    typedef enum {T_NONE, T_LOCKED, T_OPENED, T_FULL} secac_tier_t;

endpackage

// ---- hdl/secac_ctrl.sv ----
/*
 * Security tiers, key transitions, key store and settings-edit mode of a
 * battery monitor command interface.
 * Assumes the host writes and reads bytes over a slow link whose clock,
 * strobes, address and data all arrive from outside this clock domain.
 */
// What this block does
// - Enter edit mode, force protection switches off
// - Raise edit flag once mode active
// - Halt measurement and protection while editing
// - Leave edit resumes and applies new settings
// - Edit mode only from unrestricted tier
// - Locked denies settings access; opened allows reads
// - Unrestricted allows all settings; OTP only in edit mode
// - Key bytes consecutive, no write between them
// - Tier bits: 11 locked, 10 opened, 01 full
// - Unrestricted reachable by key only from opened tier
// - Key store: four big-endian words, eight bytes
// - Second key within four seconds
// - Key read: command, then eight buffer bytes
// - Key write: buffer, checksum, then length
// - Lock at boot if set; lock on on_boot_bit_a outside edit mode
// - Freeze bit blocks settings and OTP write enables
// - Permanent lock never leaves locked tier
// - Code 03 selects single-wire link
// - Codes 11, 12 select link with CRC
// - Codes 1e, 09 select link with timeouts
// - Codes 00, 08, ff fast; 07 standard
// - Link change in edit applies on leave
`timescale 1ns/1ns
module secac_ctrl #(
    parameter logic [31:0] KEY_WIN_CYC = secac_pkg::KEY_WIN_CYC,
    parameter logic [15:0] KEY_OPEN_1  = 16'h1111,
    parameter logic [15:0] KEY_OPEN_2  = 16'h2222,
    parameter logic [15:0] KEY_FULL_1  = 16'h3333,
    parameter logic [15:0] KEY_FULL_2  = 16'h4444
) (
    input  wire logic       MCLK,
    input  wire logic       NRST,
    input  wire logic       LINK_CLK,
    input  wire logic       LINK_WR,
    input  wire logic       LINK_RD,
    input  wire logic [7:0] LINK_ADDR,
    input  wire logic [7:0] LINK_DATA,
    input  wire logic       ON_BOOT_BIT_A_ON_BOOT,
    input  wire logic       FREEZE_SETTINGS,
    input  wire logic       PERMANENT_LOCK,
    input  wire logic [7:0] LINK_SEL_CFG,
    output logic [7:0]      RD_DATA,
    output logic            TIER_BIT_HIGH,
    output logic            TIER_BIT_LOW,
    output logic            SETTINGS_EDIT_FLAG,
    output logic            FET_FORCE_OFF,
    output logic            MEAS_HALT,
    output logic            APPLY_SETTINGS,
    output logic            SETTINGS_RD_ALLOW,
    output logic            SETTINGS_WR_ALLOW,
    output logic            OTP_WR_ALLOW,
    output logic            SINGLE_WIRE_HOST_LINK,
    output logic            LINK_FAST,
    output logic            LINK_CRC,
    output logic            LINK_TIMEOUT,
    output logic            LINK_SEL_RESERVED
);
    import secac_pkg::*;

    // ****************************************************************
    // Link input synchronisers and edge detection
    // ****************************************************************
    logic [18:0]  sync1;
    logic [18:0]  sync2;
    logic         clk_prev;
    logic         take;
    logic         wr_take;
    logic         rd_take;
    logic [7:0]   addr;
    logic [7:0]   data;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            sync1    <= '0;
            sync2    <= '0;
            clk_prev <= 1'b0;
        end else begin
            sync1    <= {LINK_CLK, LINK_WR, LINK_RD, LINK_ADDR, LINK_DATA};
            sync2    <= sync1;
            clk_prev <= sync2[18];
        end
    end

    assign take    = sync2[18] && !clk_prev;
    assign wr_take = take && sync2[17];
    assign rd_take = take && sync2[16];
    assign addr    = sync2[15:8];
    assign data    = sync2[7:0];

    // ****************************************************************
    // Subcommand word assembly
    // ****************************************************************
    logic         last_lo;
    logic [7:0]   lo_byte;
    logic [15:0]  last_cmd;
    logic         word_done;
    logic [15:0]  sub_word;

    assign word_done = wr_take && addr == ADDR_SUB_HI && last_lo;
    assign sub_word  = {data, lo_byte};

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            last_lo  <= 1'b0;
            lo_byte  <= 8'h00;
            last_cmd <= 16'h0000;
        end else if (wr_take) begin
            last_lo <= addr == ADDR_SUB_LO;
            if (addr == ADDR_SUB_LO)
                lo_byte <= data;
            if (word_done)
                last_cmd <= sub_word;
        end
    end

    // ****************************************************************
    // Tier state, key pairs and window
    // ****************************************************************
    secac_tier_t  tier;
    logic         edit;
    logic [15:0]  key_mem [0:KEY_WORDS-1];
    logic         pend;
    logic [31:0]  win_cnt;
    logic         can_step;
    logic [15:0]  key_a;
    logic [15:0]  key_b;
    logic         key1_hit;
    logic         key2_hit;
    logic         in_window;
    logic         cmd_on_boot_bit_a;

    assign can_step  = tier == T_OPENED || (tier == T_LOCKED && !PERMANENT_LOCK);
    assign key_a     = (tier == T_OPENED) ? key_mem[2] : key_mem[0];
    assign key_b     = (tier == T_OPENED) ? key_mem[3] : key_mem[1];
    assign in_window = win_cnt < KEY_WIN_CYC;
    assign key1_hit  = word_done && can_step && sub_word == key_a;
    assign key2_hit  = word_done && pend && can_step && in_window && sub_word == key_b;
    assign cmd_on_boot_bit_a  = word_done && sub_word == CMD_ON_BOOT_BIT_A && !edit;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            pend    <= 1'b0;
            win_cnt <= 32'h0000_0000;
        end else if (key1_hit && !key2_hit) begin
            pend    <= 1'b1;
            win_cnt <= 32'h0000_0000;
        end else if (word_done || (wr_take && addr != ADDR_SUB_LO)) begin
            pend    <= 1'b0;
        end else if (pend) begin
            if (in_window)
                win_cnt <= win_cnt + 32'h0000_0001;
            else
                pend <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            tier <= T_NONE;
        end else if (tier == T_NONE) begin
            tier <= ON_BOOT_BIT_A_ON_BOOT ? T_LOCKED : T_FULL;
        end else if (cmd_on_boot_bit_a) begin
            tier <= T_LOCKED;
        end else if (key2_hit) begin
            tier <= (tier == T_LOCKED) ? T_OPENED : T_FULL;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            TIER_BIT_HIGH <= 1'b0;
            TIER_BIT_LOW  <= 1'b0;
        end else begin
            unique case (tier)
                T_NONE:   {TIER_BIT_HIGH, TIER_BIT_LOW} <= TIER_CODE_NONE;
                T_LOCKED: {TIER_BIT_HIGH, TIER_BIT_LOW} <= TIER_CODE_LOCKED;
                T_OPENED: {TIER_BIT_HIGH, TIER_BIT_LOW} <= TIER_CODE_OPENED;
                T_FULL:   {TIER_BIT_HIGH, TIER_BIT_LOW} <= TIER_CODE_FULL;
            endcase
        end
    end

    // ****************************************************************
    // Settings-edit mode and access permissions
    // ****************************************************************
    logic         cmd_enter;
    logic         cmd_leave;

    assign cmd_enter = word_done && sub_word == CMD_ENTER_EDIT && tier == T_FULL;
    assign cmd_leave = word_done && sub_word == CMD_LEAVE_EDIT && edit;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            edit           <= 1'b0;
            APPLY_SETTINGS <= 1'b0;
        end else begin
            APPLY_SETTINGS <= cmd_leave;
            if (cmd_enter)
                edit <= 1'b1;
            else if (cmd_leave)
                edit <= 1'b0;
        end
    end

    assign SETTINGS_EDIT_FLAG = edit;
    assign FET_FORCE_OFF      = edit;
    assign MEAS_HALT          = edit;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            SETTINGS_RD_ALLOW <= 1'b0;
            SETTINGS_WR_ALLOW <= 1'b0;
            OTP_WR_ALLOW      <= 1'b0;
        end else begin
            SETTINGS_RD_ALLOW <= tier == T_OPENED || tier == T_FULL;
            SETTINGS_WR_ALLOW <= tier == T_FULL && !FREEZE_SETTINGS;
            OTP_WR_ALLOW      <= tier == T_FULL && edit && !FREEZE_SETTINGS;
        end
    end

    // ****************************************************************
    // Key store transfer buffer
    // ****************************************************************
    logic [7:0]   buf_mem [0:BUF_BYTES-1];
    logic [7:0]   csum;
    logic [7:0]   buf_sum;
    logic         buf_hit;
    logic [2:0]   buf_idx;
    logic         len_wr;
    logic         store_ok;

    assign buf_hit = addr >= ADDR_BUF_FIRST && addr <= ADDR_BUF_LAST;
    assign buf_idx = addr[2:0];
    assign len_wr  = wr_take && addr == ADDR_LEN && last_cmd == CMD_KEY_STORE;

    always_comb begin
        buf_sum = CMD_KEY_STORE[7:0] + CMD_KEY_STORE[15:8];
        for (int i = 0; i < BUF_BYTES; i++)
            buf_sum = buf_sum + buf_mem[i];
    end

    assign store_ok = len_wr && data == KEY_STORE_LEN && csum == ~buf_sum
                      && tier == T_FULL;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            csum <= 8'h00;
            for (int i = 0; i < BUF_BYTES; i++)
                buf_mem[i] <= 8'h00;
        end else if (word_done && sub_word == CMD_KEY_STORE && tier != T_LOCKED) begin
            for (int i = 0; i < KEY_WORDS; i++) begin
                buf_mem[2*i]   <= key_mem[i][15:8];
                buf_mem[2*i+1] <= key_mem[i][7:0];
            end
        end else if (wr_take && buf_hit) begin
            buf_mem[buf_idx] <= data;
        end else if (wr_take && addr == ADDR_CSUM) begin
            csum <= data;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            key_mem[0] <= KEY_OPEN_1;
            key_mem[1] <= KEY_OPEN_2;
            key_mem[2] <= KEY_FULL_1;
            key_mem[3] <= KEY_FULL_2;
        end else if (store_ok) begin
            for (int i = 0; i < KEY_WORDS; i++)
                key_mem[i] <= {buf_mem[2*i], buf_mem[2*i+1]};
        end
    end

    // ****************************************************************
    // Host read data
    // ****************************************************************
    always_ff @(posedge MCLK) begin
        if (!NRST)
            RD_DATA <= 8'h00;
        else if (rd_take) begin
            if (addr == ADDR_SUB_LO)
                RD_DATA <= last_cmd[7:0];
            else if (addr == ADDR_SUB_HI)
                RD_DATA <= last_cmd[15:8];
            else if (buf_hit)
                RD_DATA <= buf_mem[buf_idx];
            else
                RD_DATA <= 8'h00;
        end
    end

    // ****************************************************************
    // Host link selection
    // ****************************************************************
    logic [7:0]   link_sel;
    logic         sel_load;

    assign sel_load = tier == T_NONE || cmd_leave;

    always_ff @(posedge MCLK) begin
        if (!NRST)
            link_sel <= LSEL_DEFAULT;
        else if (sel_load)
            link_sel <= LINK_SEL_CFG;
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            SINGLE_WIRE_HOST_LINK <= 1'b0;
            LINK_FAST             <= 1'b1;
            LINK_CRC              <= 1'b0;
            LINK_TIMEOUT          <= 1'b0;
            LINK_SEL_RESERVED     <= 1'b0;
        end else begin
            SINGLE_WIRE_HOST_LINK <= link_sel == LSEL_SINGLE;
            LINK_FAST             <= link_sel == LSEL_DEFAULT || link_sel == LSEL_FAST
                                     || link_sel == LSEL_FAST_ALT || link_sel == LSEL_FAST_CRC
                                     || link_sel == LSEL_FAST_TMO;
            LINK_CRC              <= link_sel == LSEL_STD_CRC || link_sel == LSEL_FAST_CRC;
            LINK_TIMEOUT          <= link_sel == LSEL_STD_TMO || link_sel == LSEL_FAST_TMO;
            LINK_SEL_RESERVED     <= !(link_sel inside {LSEL_DEFAULT, LSEL_SINGLE, LSEL_STD,
                                       LSEL_FAST, LSEL_FAST_TMO, LSEL_STD_CRC, LSEL_FAST_CRC,
                                       LSEL_STD_TMO, LSEL_FAST_ALT});
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    logic [63:0] key_flat;
    assign key_flat = {key_mem[0], key_mem[1], key_mem[2], key_mem[3]};

    sequence s_first_key;
        key1_hit && !key2_hit;
    endsequence

    sequence s_second_key;
        key2_hit && !cmd_on_boot_bit_a;
    endsequence

    chk_edit_entry: assert property (cmd_enter |=> SETTINGS_EDIT_FLAG && FET_FORCE_OFF)
        else $error("edit mode not entered");
    chk_edit_flag: assert property (SETTINGS_EDIT_FLAG && !cmd_leave |=> SETTINGS_EDIT_FLAG && MEAS_HALT)
        else $error("edit flag without halt");
    chk_edit_tier: assert property (SETTINGS_EDIT_FLAG |-> tier == T_FULL)
        else $error("edit mode outside full tier");
    chk_leave_apply: assert property (cmd_leave |=> !SETTINGS_EDIT_FLAG && APPLY_SETTINGS)
        else $error("leave did not apply");
    chk_no_skip: assert property (tier == T_LOCKED |=> tier != T_FULL)
        else $error("locked jumped to full");
    chk_perm_hold: assert property (tier == T_LOCKED && PERMANENT_LOCK |=> tier == T_LOCKED)
        else $error("left permanent lock");
    chk_on_boot_bit_a_locks: assert property (cmd_on_boot_bit_a |=> tier == T_LOCKED ##1 TIER_BIT_HIGH && TIER_BIT_LOW)
        else $error("on_boot_bit_a did not lock");
    chk_pair_step: assert property (s_first_key ##[1:1000] s_second_key
                                    |=> tier != $past(tier))
        else $error("valid key pair ignored");
    chk_key_mismatch: assert property (word_done && !key2_hit && !cmd_on_boot_bit_a && tier != T_NONE
                                       |=> $stable(tier))
        else $error("tier changed on bad key");
    chk_link_hold: assert property (SETTINGS_EDIT_FLAG && !cmd_leave |=> $stable(link_sel))
        else $error("link select changed in edit");
    chk_bad_store: assert property (len_wr && !store_ok |=> $stable(key_flat))
        else $error("keys changed on bad store");
    chk_freeze: assert property (FREEZE_SETTINGS ##1 FREEZE_SETTINGS |-> !SETTINGS_WR_ALLOW)
        else $error("write allowed while frozen");

endmodule

// ---- test/secac_host.sv ----
/*
 * Host link model: byte writes and reads on the slow link to the controller.
 * Assumes it is paced by the core clock; link clock idles low between frames.
 */
`timescale 1ns/1ns
module secac_host (
    input  wire logic       mclk,
    output logic            link_clk,
    output logic            link_wr,
    output logic            link_rd,
    output logic [7:0]      link_addr,
    output logic [7:0]      link_data
);
    initial begin
        link_clk  = 1'b0;
        link_wr   = 1'b0;
        link_rd   = 1'b0;
        link_addr = 8'h00;
        link_data = 8'h00;
    end
    // One transfer, 80 ns link period; lines change only while the link clock is low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        link_wr   = wr;
        link_rd   = ~wr;
        link_addr = a;
        link_data = d;
        repeat (4) @(posedge mclk);
        #1 link_clk = 1'b1;
        repeat (4) @(posedge mclk);
        #1 link_clk = 1'b0;
    endtask
    // End of frame: released lines do not keep their last value
    task automatic fin;
        link_wr   = 1'b0;
        link_rd   = 1'b0;
        link_addr = ~link_addr;
        link_data = ~link_data;
        repeat (6) @(posedge mclk);
        #1;
    endtask
    // Word on the subcommand port, low byte then high byte, nothing between
    task automatic word(input logic [15:0] w);
        xfer(1'b1, secac_pkg::ADDR_SUB_LO, w[7:0]);
        xfer(1'b1, secac_pkg::ADDR_SUB_HI, w[15:8]);
    endtask
endmodule

// ---- test/secac_ctrl_test.sv ----
/*
 * Self-checking bench for the security and settings-access controller.
 * Assumes secac_pkg, secac_ctrl and the host link model secac_host.
 */
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] %0t ns: got %0h expected %0h", $time, (a), (e)); end end
module secac_ctrl_test;
    import secac_pkg::*;
    logic        mclk = 1'b0;
    logic        nrst, sob, freeze, perm;
    logic [7:0]  lsel, rd_data;
    logic        link_clk, link_wr, link_rd;
    logic [7:0]  link_addr, link_data;
    logic        th, tl, edit, fet, meas, apply, rd_ok, wr_ok, otp;
    logic        single, fast, crc, tmo, rsv;
    logic [4:0]  lnk;
    logic [15:0] keys [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    logic [15:0] nkeys [4];
    logic [15:0] lfsr = 16'haf2e;
    logic [7:0]  codes [10] = '{8'h00, 8'h03, 8'h07, 8'h08, 8'h09, 8'h11, 8'h12, 8'h1e,
                                8'hff, 8'h04};
    logic [7:0]  c;
    int          failures = 0;
    int          total_checks = 0;
    int          apply_cnt = 0;

    assign lnk = {single, fast, crc, tmo, rsv};
    always #5 mclk = ~mclk;
    always @(negedge mclk) if (apply === 1'b1) apply_cnt <= apply_cnt + 1;

    secac_host host_u (.mclk(mclk), .link_clk(link_clk), .link_wr(link_wr),
        .link_rd(link_rd), .link_addr(link_addr), .link_data(link_data));

    secac_ctrl #(.KEY_WIN_CYC(32'h0000_00c8)) dut_u (.MCLK(mclk), .NRST(nrst),
        .LINK_CLK(link_clk), .LINK_WR(link_wr), .LINK_RD(link_rd),
        .LINK_ADDR(link_addr), .LINK_DATA(link_data), .ON_BOOT_BIT_A_ON_BOOT(sob),
        .FREEZE_SETTINGS(freeze), .PERMANENT_LOCK(perm), .LINK_SEL_CFG(lsel),
        .RD_DATA(rd_data), .TIER_BIT_HIGH(th), .TIER_BIT_LOW(tl),
        .SETTINGS_EDIT_FLAG(edit), .FET_FORCE_OFF(fet), .MEAS_HALT(meas),
        .APPLY_SETTINGS(apply), .SETTINGS_RD_ALLOW(rd_ok), .SETTINGS_WR_ALLOW(wr_ok),
        .OTP_WR_ALLOW(otp), .SINGLE_WIRE_HOST_LINK(single), .LINK_FAST(fast),
        .LINK_CRC(crc), .LINK_TIMEOUT(tmo), .LINK_SEL_RESERVED(rsv));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected decode {single, fast, crc, timeout, reserved}
    function automatic logic [4:0] exp_link(input logic [7:0] v);
        case (v)
            8'h00, 8'h08, 8'hff: return 5'b01000;
            8'h03: return 5'b10000;
            8'h07: return 5'b00000;
            8'h09: return 5'b01010;
            8'h11: return 5'b00100;
            8'h12: return 5'b01100;
            8'h1e: return 5'b00010;
            default: return 5'b00001;
        endcase
    endfunction
    task automatic sync;
        @(posedge mclk) #1;
    endtask
    task automatic cmd(input logic [15:0] w);
        host_u.word(w);
        host_u.fin();
    endtask
    task automatic pair(input logic [15:0] a, input logic [15:0] b);
        host_u.word(a);
        host_u.word(b);
        host_u.fin();
    endtask
    task automatic do_reset;
        nrst = 1'b0;
        repeat (4) sync();
        nrst = 1'b1;
        repeat (3) sync();
    endtask
    task automatic key_read;
        cmd(CMD_KEY_STORE);
        host_u.xfer(1'b0, ADDR_SUB_LO, 8'h00);
        host_u.fin();
        `CHK(rd_data, CMD_KEY_STORE[7:0])
        for (int i = 0; i < BUF_BYTES; i++) begin
            host_u.xfer(1'b0, ADDR_BUF_FIRST + 8'(i), 8'h00);
            host_u.fin();
            `CHK(rd_data, i[0] ? keys[i/2][7:0] : keys[i/2][15:8])
        end
    endtask
    task automatic key_write(input logic [7:0] bad);
        logic [7:0] sum;
        logic [7:0] b;
        sum = 8'h35;
        host_u.word(CMD_KEY_STORE);
        for (int i = 0; i < BUF_BYTES; i++) begin
            b = i[0] ? nkeys[i/2][7:0] : nkeys[i/2][15:8];
            sum = sum + b;
            host_u.xfer(1'b1, ADDR_BUF_FIRST + 8'(i), b);
        end
        host_u.xfer(1'b1, ADDR_CSUM, ~sum ^ bad);
        host_u.xfer(1'b1, ADDR_LEN, KEY_STORE_LEN);
        host_u.fin();
        if (bad == 8'h00) keys = nkeys;
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (100000) @(posedge mclk);
        failures++;
        finish_test();
    end
    initial begin
        nrst = 1'b0;
        sob = 1'b1;
        freeze = 1'b0;
        perm = 1'b0;
        lsel = LSEL_FAST_CRC;
        repeat (16) sync();
        `CHK({th, tl, fast}, 3'b001)
        nrst = 1'b1;
        repeat (3) sync();
        `CHK({th, tl}, TIER_CODE_LOCKED)
        `CHK(rd_ok, 1'b0)
        pair(keys[2], keys[3]);
        `CHK({th, tl}, TIER_CODE_LOCKED)
        lfsr = lfsr_next(lfsr);
        pair(keys[0], keys[1] ^ (lfsr | 16'h0001));
        `CHK({th, tl}, TIER_CODE_LOCKED)
        host_u.word(keys[0]);
        host_u.xfer(1'b1, ADDR_BUF_FIRST, lfsr[7:0]);
        pair(keys[1], 16'h0000);
        `CHK({th, tl}, TIER_CODE_LOCKED)
        cmd(keys[0]);
        repeat (250) sync();
        cmd(keys[1]);
        `CHK({th, tl}, TIER_CODE_LOCKED)
        pair(keys[0], keys[1]);
        `CHK({th, tl, rd_ok, wr_ok}, {TIER_CODE_OPENED, 2'b10})
        cmd(CMD_ENTER_EDIT);
        `CHK(edit, 1'b0)
        pair(keys[2], keys[3]);
        `CHK({th, tl, wr_ok}, {TIER_CODE_FULL, 1'b1})
        key_read();
        for (int i = 0; i < KEY_WORDS; i++) begin
            lfsr = lfsr_next(lfsr);
            nkeys[i] = lfsr;
        end
        key_write(8'h00);
        key_read();
        nkeys[0] = ~nkeys[0];
        key_write(lfsr[7:0] | 8'h01);
        key_read();
        cmd(CMD_ENTER_EDIT);
        `CHK({edit, fet, meas, otp}, 4'hf)
        freeze = 1'b1;
        repeat (3) sync();
        `CHK({otp, wr_ok}, 2'b00)
        freeze = 1'b0;
        lsel = LSEL_SINGLE;
        repeat (3) sync();
        `CHK(lnk, exp_link(LSEL_FAST_CRC))
        cmd(CMD_LEAVE_EDIT);
        `CHK({edit, fet, meas, apply_cnt[1:0]}, 5'b00001)
        `CHK(lnk, exp_link(LSEL_SINGLE))
        cmd(CMD_ON_BOOT_BIT_A);
        `CHK({th, tl}, TIER_CODE_LOCKED)
        perm = 1'b1;
        pair(keys[0], keys[1]);
        `CHK({th, tl}, TIER_CODE_LOCKED)
        perm = 1'b0;
        sob = 1'b0;
        for (int i = 0; i < 13; i++) begin
            lfsr = lfsr_next(lfsr);
            c = (i < 10) ? codes[i] : lfsr[7:0];
            lsel = c;
            do_reset();
            `CHK(lnk, exp_link(c))
        end
        `CHK({th, tl}, TIER_CODE_FULL)
        finish_test();
    end
endmodule
